/* src/seq_pkg.sv */
// Purpose: Shared constants for the analyzer self-test sequencer.
// Assumes: 200 MHz core clock.
// Notes:   Failure codes hold five hex digits plus a one-digit suffix.
package seq_pkg;
  localparam int unsigned CLK_MHZ   = 200;
  localparam int unsigned WAIT1_MS  = 46;
  localparam int unsigned WAIT2_MS  = 8;
  localparam int unsigned WAIT1_CYC = WAIT1_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAIT2_CYC = WAIT2_MS * 1000 * CLK_MHZ;
  localparam int unsigned US_CYC    = CLK_MHZ;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h1;
  localparam logic [3:0]  REG_FAIL   = 4'h2;
  localparam logic [3:0]  REG_WAIT   = 4'h3;
  localparam logic [3:0]  REG_EXPCTR = 4'h4;
  localparam logic [3:0]  REG_EXPSUM = 4'h5;
  localparam logic [3:0]  REG_QUALA  = 4'h6;
  localparam logic [3:0]  REG_QUALB  = 4'h7;
  localparam logic [3:0]  REG_ISTAT  = 4'h8;
  localparam logic [3:0]  REG_IMASK  = 4'h9;
  localparam logic [19:0] CODE_SLOW  = 20'h0FF60;
  localparam logic [19:0] CODE_MON   = 20'h2E803;
  localparam logic [19:0] CODE_EARLY = 20'h02E80;
  localparam logic [19:0] CODE_C1H   = 20'h1E202;
  localparam logic [19:0] CODE_C1L   = 20'h1E203;
  localparam logic [19:0] CODE_C2H   = 20'h1E302;
  localparam logic [19:0] CODE_C2L   = 20'h1E303;
  localparam logic [19:0] CODE_SUM   = 20'h3E035;
  localparam logic [19:0] CODE_QUAL  = 20'h3E039;
  localparam logic [3:0]  DIG_SLOW   = 4'h1;
  localparam logic [3:0]  DIG_NOTRIG = 4'h7;
  localparam logic [3:0]  DIG_FULL   = 4'h5;
  localparam logic [3:0]  DIG_EARLY1 = 4'h3;
  localparam logic [3:0]  DIG_EARLY2 = 4'h2;
  localparam logic [15:0] PRELOAD_MS = 16'h0030;
  localparam logic [15:0] PRELOAD_US = 16'hC34E;
  localparam logic [7:0]  DELAY_T4   = 8'hF0;
  localparam logic [9:0]  MEM_LAST   = 10'h3FF;
  localparam logic [2:0]  QUAL_LAST  = 3'h5;
  localparam logic [3:0]  TEST4      = 4'h4;
  localparam logic [3:0]  TEST5      = 4'h5;
  localparam logic [3:0]  TEST6      = 4'h6;
  localparam logic [3:0]  TEST7      = 4'h7;
  typedef enum logic [1:0] {CMD_NONE, CMD_STORE, CMD_VIEW} cmd_t;
  typedef enum logic [1:0] {PROG_CHAIN, PROG_MS, PROG_US, PROG_QUAL} prog_t;
endpackage : seq_pkg

/* src/test_sequencer.sv */
// Purpose: Runs analyzer trigger-path self tests and reports failure codes.
// Assumes: Analyzer hardware sits on mclk_in; memory data follows a read by one cycle.
// Notes:   Tests 4 to 7; software selects one test and starts it.
// Notes on behaviour
// - After store and stored wait, still capturing reports failed-to-trigger.
// - Once triggered, a view command goes out before anything else.
// - Memory-full flag must be set, else dedicated failure code.
// - Compare counter one high, low, then counter two; code carries first bad bit.
// - After counters pass, sum all memory bytes and compare with expected sum.
// - Slow-clock detector checked once per test, before the first store command.
// - Millisecond test program: counter one runs 50 ms, counter two stopped.
// - Counters preloaded with count minus two, decrementing, ms base, zero delay.
// - Wait 46 ms, back in view means premature; else 8 ms more then check.
// - Microsecond test mirrors it with counter two preloaded 49998.
// - Counter two early return to view reports its own premature code.
// - Time base and sequencer share one reference; only function is checked.
// - Qualifier test triggers on word match one, which the line suppresses.
// - In qualifier test no trigger passes, return to view fails.
// - Six lines in turn: latch value, store, wait, check; stop at first failure.
// - Qualifier failure code low digit names the line, consecutive codes.
// - Chained test uses 240 state-clock acquisition delay after trigger.
`timescale 1ns/1ps
module test_sequencer #(
  parameter int unsigned WAIT1_CYCLES = seq_pkg::WAIT1_CYC,
  parameter int unsigned WAIT2_CYCLES = seq_pkg::WAIT2_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             irq_out,
  input  wire logic        capturing_in,
  input  wire logic        mem_full_in,
  input  wire logic        slow_clock_in,
  input  wire logic [15:0] ctr_one_in,
  input  wire logic [15:0] ctr_two_in,
  input  wire logic [7:0]  mem_data_in,
  output logic      [1:0]  cmd_out,
  output logic      [1:0]  prog_out,
  output logic             prog_wr_out,
  output logic      [15:0] ctr_one_load_out,
  output logic      [15:0] ctr_two_load_out,
  output logic             ctr_dec_mode_out,
  output logic             ctr_one_ms_out,
  output logic             ctr_two_us_out,
  output logic      [7:0]  acq_delay_out,
  output logic      [7:0]  fe_latch_out,
  output logic             fe_latch_wr_out,
  output logic      [9:0]  mem_addr_out,
  output logic             mem_rd_out
);
  typedef enum logic [3:0] {S_IDLE, S_SETUP, S_CLK, S_QLATCH, S_STORE, S_WAIT, S_POLL,
    S_WAIT2, S_POLL2, S_VIEW, S_FULL, S_CTR, S_SUM, S_SUMEND, S_PASS, S_FAIL} state_t;

  state_t      state_q;
  logic [3:0]  test_q;
  logic [31:0] timer_q;
  logic [2:0]  qual_q;
  logic [1:0]  byte_q;
  logic [15:0] sum_q;
  logic        rd_pend_q;
  logic [15:0] wait_us_q;
  logic [31:0] exp_ctr_q;
  logic [15:0] exp_sum_q;
  logic [47:0] qual_vals_q;
  logic [27:0] fail_q;
  logic        busy_q;
  logic        passed_q;
  logic [1:0]  istat_q;
  logic [1:0]  imask_q;
  logic [23:0] code_d;
  logic        done_pass;
  logic        done_fail;
  logic [7:0]  got_byte;
  logic [7:0]  exp_byte;
  logic [19:0] ctr_code;

  // Index of the lowest differing bit, scanning from bit 15 downward.
  function automatic logic [3:0] first_bad(input logic [15:0] diff);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (diff[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_bad

  assign done_pass = ce_in && state_q == S_PASS;
  assign done_fail = ce_in && state_q == S_FAIL;

  always_comb begin
    case (byte_q)
      2'h0: begin got_byte = ctr_one_in[15:8]; exp_byte = exp_ctr_q[31:24]; ctr_code = seq_pkg::CODE_C1H; end
      2'h1: begin got_byte = ctr_one_in[7:0];  exp_byte = exp_ctr_q[23:16]; ctr_code = seq_pkg::CODE_C1L; end
      2'h2: begin got_byte = ctr_two_in[15:8]; exp_byte = exp_ctr_q[15:8];  ctr_code = seq_pkg::CODE_C2H; end
      default: begin got_byte = ctr_two_in[7:0]; exp_byte = exp_ctr_q[7:0]; ctr_code = seq_pkg::CODE_C2L; end
    endcase
  end

  // Failure code chosen in the state that detects it.
  always_comb begin
    code_d = 24'h000000;
    case (state_q)
      S_CLK:  code_d = {seq_pkg::CODE_SLOW, seq_pkg::DIG_SLOW};
      S_POLL: begin
        if (test_q == seq_pkg::TEST4) begin
          code_d = {seq_pkg::CODE_MON, seq_pkg::DIG_NOTRIG};
        end else if (test_q == seq_pkg::TEST5) begin
          code_d = {seq_pkg::CODE_EARLY, seq_pkg::DIG_EARLY1};
        end else if (test_q == seq_pkg::TEST6) begin
          code_d = {seq_pkg::CODE_MON, seq_pkg::DIG_EARLY2};
        end else begin
          code_d = {seq_pkg::CODE_QUAL + 20'(qual_q), 4'h0};
        end
      end
      S_POLL2: code_d = {seq_pkg::CODE_MON, seq_pkg::DIG_NOTRIG};
      S_FULL:  code_d = {seq_pkg::CODE_MON, seq_pkg::DIG_FULL};
      S_CTR:   code_d = {ctr_code, first_bad({8'h00, got_byte ^ exp_byte})};
      S_SUMEND: code_d = {seq_pkg::CODE_SUM, first_bad(sum_q ^ exp_sum_q)};
      default: code_d = 24'h000000;
    endcase
  end

  // Test sequencing; the timeout counts only test function, not accuracy.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      test_q  <= 4'h0;
      timer_q <= 32'h00000000;
      qual_q  <= 3'h0;
      byte_q  <= 2'h0;
      fail_q  <= 28'h0000000;
    end else if (ce_in) begin
      case (state_q)
        S_IDLE: begin
          if (wr_in && addr_in == seq_pkg::REG_CTRL && wdata_in[0]) begin
            test_q  <= wdata_in[7:4];
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          qual_q  <= 3'h0;
          state_q <= S_CLK;
        end
        S_CLK: begin
          if (slow_clock_in) begin
            fail_q  <= {test_q, code_d};
            state_q <= S_FAIL;
          end else if (test_q == seq_pkg::TEST7) begin
            state_q <= S_QLATCH;
          end else begin
            state_q <= S_STORE;
          end
        end
        S_QLATCH: state_q <= S_STORE;
        S_STORE: begin
          if (test_q == seq_pkg::TEST5 || test_q == seq_pkg::TEST6) begin
            timer_q <= WAIT1_CYCLES;
          end else begin
            timer_q <= 32'(wait_us_q) * seq_pkg::US_CYC;
          end
          state_q <= S_WAIT;
        end
        S_WAIT, S_WAIT2: begin
          if (timer_q <= 32'h00000001) begin
            state_q <= (state_q == S_WAIT) ? S_POLL : S_POLL2;
          end else begin
            timer_q <= timer_q - 32'h00000001;
          end
        end
        S_POLL: begin
          if (test_q == seq_pkg::TEST4) begin
            if (capturing_in) begin
              fail_q  <= {test_q, code_d};
              state_q <= S_FAIL;
            end else begin
              state_q <= S_VIEW;
            end
          end else if (test_q == seq_pkg::TEST7) begin
            if (!capturing_in) begin
              fail_q  <= {test_q, code_d};
              state_q <= S_FAIL;
            end else begin
              state_q <= S_VIEW;
            end
          end else if (!capturing_in) begin
            fail_q  <= {test_q, code_d};
            state_q <= S_FAIL;
          end else begin
            timer_q <= WAIT2_CYCLES;
            state_q <= S_WAIT2;
          end
        end
        S_POLL2: begin
          if (capturing_in) begin
            fail_q  <= {test_q, code_d};
            state_q <= S_FAIL;
          end else begin
            state_q <= S_VIEW;
          end
        end
        S_VIEW: begin
          if (test_q == seq_pkg::TEST4) begin
            state_q <= S_FULL;
          end else if (test_q == seq_pkg::TEST7 && qual_q != seq_pkg::QUAL_LAST) begin
            qual_q  <= qual_q + 3'h1;
            state_q <= S_QLATCH;
          end else begin
            state_q <= S_PASS;
          end
        end
        S_FULL: begin
          byte_q <= 2'h0;
          if (!mem_full_in) begin
            fail_q  <= {test_q, code_d};
            state_q <= S_FAIL;
          end else begin
            state_q <= S_CTR;
          end
        end
        S_CTR: begin
          if (got_byte != exp_byte) begin
            fail_q  <= {test_q, code_d};
            state_q <= S_FAIL;
          end else if (byte_q == 2'h3) begin
            state_q <= S_SUM;
          end else begin
            byte_q <= byte_q + 2'h1;
          end
        end
        S_SUM: begin
          if (mem_addr_out == seq_pkg::MEM_LAST && mem_rd_out) begin
            state_q <= S_SUMEND;
          end
        end
        S_SUMEND: begin
          if (!mem_rd_out && !rd_pend_q) begin
            if (sum_q != exp_sum_q) begin
              fail_q  <= {test_q, code_d};
              state_q <= S_FAIL;
            end else begin
              state_q <= S_PASS;
            end
          end
        end
        S_PASS, S_FAIL: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Analyzer programming and commands, one cycle per state entry.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cmd_out          <= seq_pkg::CMD_NONE;
      prog_out         <= seq_pkg::PROG_CHAIN;
      prog_wr_out      <= 1'b0;
      ctr_one_load_out <= 16'h0000;
      ctr_two_load_out <= 16'h0000;
      ctr_dec_mode_out <= 1'b0;
      ctr_one_ms_out   <= 1'b0;
      ctr_two_us_out   <= 1'b0;
      acq_delay_out    <= 8'h00;
      fe_latch_out     <= 8'h00;
      fe_latch_wr_out  <= 1'b0;
    end else if (ce_in) begin
      cmd_out         <= seq_pkg::CMD_NONE;
      prog_wr_out     <= 1'b0;
      fe_latch_wr_out <= 1'b0;
      case (state_q)
        S_SETUP: begin
          prog_wr_out <= 1'b1;
          cmd_out     <= seq_pkg::CMD_VIEW;
          case (test_q)
            seq_pkg::TEST5: begin
              prog_out         <= seq_pkg::PROG_MS;
              ctr_one_load_out <= seq_pkg::PRELOAD_MS;
              ctr_two_load_out <= seq_pkg::PRELOAD_MS;
              ctr_dec_mode_out <= 1'b1;
              ctr_one_ms_out   <= 1'b1;
              ctr_two_us_out   <= 1'b0;
              acq_delay_out    <= 8'h00;
            end
            seq_pkg::TEST6: begin
              prog_out         <= seq_pkg::PROG_US;
              ctr_one_load_out <= seq_pkg::PRELOAD_US;
              ctr_two_load_out <= seq_pkg::PRELOAD_US;
              ctr_dec_mode_out <= 1'b1;
              ctr_one_ms_out   <= 1'b0;
              ctr_two_us_out   <= 1'b1;
              acq_delay_out    <= 8'h00;
            end
            seq_pkg::TEST7: begin
              prog_out         <= seq_pkg::PROG_QUAL;
              ctr_dec_mode_out <= 1'b0;
              acq_delay_out    <= 8'h00;
            end
            default: begin
              prog_out         <= seq_pkg::PROG_CHAIN;
              ctr_dec_mode_out <= 1'b0;
              acq_delay_out    <= seq_pkg::DELAY_T4;
            end
          endcase
        end
        S_QLATCH: begin
          fe_latch_out    <= qual_vals_q[8*qual_q +: 8];
          fe_latch_wr_out <= 1'b1;
        end
        S_STORE: cmd_out <= seq_pkg::CMD_STORE;
        S_VIEW:  cmd_out <= seq_pkg::CMD_VIEW;
        default: cmd_out <= seq_pkg::CMD_NONE;
      endcase
    end
  end

  // Memory sweep and byte sum; data arrives the cycle after each read.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mem_addr_out <= 10'h000;
      mem_rd_out   <= 1'b0;
      rd_pend_q    <= 1'b0;
      sum_q        <= 16'h0000;
    end else if (ce_in) begin
      rd_pend_q <= mem_rd_out;
      if (state_q == S_CTR) begin
        mem_addr_out <= 10'h000;
        mem_rd_out   <= 1'b0;
        sum_q        <= 16'h0000;
      end else if (state_q == S_SUM) begin
        mem_rd_out <= !(mem_addr_out == seq_pkg::MEM_LAST && mem_rd_out);
        if (mem_rd_out && mem_addr_out != seq_pkg::MEM_LAST) begin
          mem_addr_out <= mem_addr_out + 10'h001;
        end
      end else begin
        mem_rd_out <= 1'b0;
      end
      if (rd_pend_q) begin
        sum_q <= sum_q + {8'h00, mem_data_in};
      end
    end
  end

  // Software settings.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wait_us_q   <= 16'h0000;
      exp_ctr_q   <= 32'h00000000;
      exp_sum_q   <= 16'h0000;
      qual_vals_q <= 48'h000000000000;
      imask_q     <= 2'h0;
    end else if (ce_in && wr_in) begin
      case (addr_in)
        seq_pkg::REG_WAIT:   wait_us_q <= wdata_in[15:0];
        seq_pkg::REG_EXPCTR: exp_ctr_q <= wdata_in;
        seq_pkg::REG_EXPSUM: exp_sum_q <= wdata_in[15:0];
        seq_pkg::REG_QUALA:  qual_vals_q[31:0] <= wdata_in;
        seq_pkg::REG_QUALB:  qual_vals_q[47:32] <= wdata_in[15:0];
        seq_pkg::REG_IMASK:  imask_q <= wdata_in[1:0];
        default: imask_q <= imask_q;
      endcase
    end
  end

  // Status, sticky events (set beats write-one clear) and interrupt.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      busy_q   <= 1'b0;
      passed_q <= 1'b0;
      istat_q  <= 2'h0;
      irq_out  <= 1'b0;
    end else if (ce_in) begin
      busy_q  <= state_q != S_IDLE && state_q != S_PASS && state_q != S_FAIL;
      if (done_pass) begin
        passed_q <= 1'b1;
      end else if (done_fail) begin
        passed_q <= 1'b0;
      end
      istat_q <= (istat_q & ~((wr_in && addr_in == seq_pkg::REG_ISTAT) ? wdata_in[1:0] : 2'h0))
                 | {done_fail, done_pass};
      irq_out <= |(istat_q & imask_q);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      rdata_out <= 32'h00000000;
      if (rd_in) begin
        case (addr_in)
          seq_pkg::REG_CTRL:   rdata_out <= {24'h000000, test_q, 4'h0};
          seq_pkg::REG_STATUS: rdata_out <= {28'h0000000, 1'b0, fail_q != 28'h0, passed_q, busy_q};
          seq_pkg::REG_FAIL:   rdata_out <= {4'h0, fail_q};
          seq_pkg::REG_WAIT:   rdata_out <= {16'h0000, wait_us_q};
          seq_pkg::REG_EXPCTR: rdata_out <= exp_ctr_q;
          seq_pkg::REG_EXPSUM: rdata_out <= {16'h0000, exp_sum_q};
          seq_pkg::REG_QUALA:  rdata_out <= qual_vals_q[31:0];
          seq_pkg::REG_QUALB:  rdata_out <= {16'h0000, qual_vals_q[47:32]};
          seq_pkg::REG_ISTAT:  rdata_out <= {30'h00000000, istat_q};
          seq_pkg::REG_IMASK:  rdata_out <= {30'h00000000, imask_q};
          default: rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in || !ce_in);

  a_notrig_code: assert property (state_q == S_POLL && test_q == seq_pkg::TEST4 && capturing_in |=>
    state_q == S_FAIL && fail_q == {seq_pkg::TEST4, seq_pkg::CODE_MON, seq_pkg::DIG_NOTRIG})
    else $error("missing failed-to-trigger code");
  a_view_first: assert property (state_q == S_POLL && test_q == seq_pkg::TEST4 && !capturing_in
    |=> ##1 cmd_out == seq_pkg::CMD_VIEW) else $error("view command not sent after trigger");
  a_full_check: assert property (state_q == S_FULL && !mem_full_in |=> fail_q[3:0] == 4'h5)
    else $error("memory full failure code wrong");
  a_no_clock: assert property (state_q == S_CLK && slow_clock_in |=> ##1
    cmd_out != seq_pkg::CMD_STORE && state_q == S_IDLE) else $error("store sent without clock");
  a_ms_load: assert property (state_q == S_SETUP && test_q == seq_pkg::TEST5 |=>
    ctr_one_load_out == seq_pkg::PRELOAD_MS && ctr_one_ms_out && ctr_dec_mode_out && acq_delay_out == 8'h00)
    else $error("millisecond setup wrong");
  a_us_load: assert property (state_q == S_SETUP && test_q == seq_pkg::TEST6 |=>
    ctr_two_load_out == seq_pkg::PRELOAD_US && ctr_two_us_out) else $error("microsecond setup wrong");
  a_early_code: assert property (state_q == S_POLL && test_q == seq_pkg::TEST6 && !capturing_in |=>
    fail_q[23:0] == {seq_pkg::CODE_MON, seq_pkg::DIG_EARLY2}) else $error("counter two early code wrong");
  a_qual_code: assert property (state_q == S_POLL && test_q == seq_pkg::TEST7 && !capturing_in |=>
    fail_q[23:4] == seq_pkg::CODE_QUAL + 20'($past(qual_q))) else $error("qualifier code wrong");
  a_sum_fail: assert property (state_q == S_SUMEND && !mem_rd_out && !rd_pend_q && sum_q != exp_sum_q
    |=> fail_q[23:4] == seq_pkg::CODE_SUM) else $error("checksum failure not reported");
  a_store_wait: assert property (cmd_out == seq_pkg::CMD_STORE && test_q == seq_pkg::TEST5 |->
    state_q == S_WAIT && timer_q == WAIT1_CYCLES) else $error("first wait not loaded");

  c_pass: cover property (state_q == S_PASS && test_q == seq_pkg::TEST4);
  c_qual_fail: cover property (state_q == S_FAIL && test_q == seq_pkg::TEST7);
  c_second_wait: cover property (state_q == S_POLL2);
endmodule : test_sequencer

/* sim/analyzer_model.sv */
// Purpose: Far-side model of the analyzer capture, trigger and memory hardware.
// Assumes: Commands and memory reads arrive on mclk_in.
// Notes:   A zero trigger delay means the main section never triggers.
`timescale 1ns/1ps
module analyzer_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [1:0]  cmd_in,
  input  wire logic [7:0]  latch_in,
  input  wire logic [7:0]  bad_latch_in,
  input  wire logic        qual_chk_in,
  input  wire logic [15:0] trig_dly_in,
  input  wire logic [9:0]  mem_addr_in,
  input  wire logic        mem_rd_in,
  input  wire logic [7:0]  pat_in,
  output logic             capturing_out,
  output logic      [7:0]  mem_data_out
);
  logic [15:0] cnt_q;
  // A working qualifier line hides the matching word, so no trigger follows.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      capturing_out <= 1'b0;
      cnt_q         <= 16'h0000;
    end else if (cmd_in == seq_pkg::CMD_STORE) begin
      capturing_out <= 1'b1;
      cnt_q         <= (qual_chk_in && latch_in != bad_latch_in) ? 16'h0000 : trig_dly_in;
    end else if (cmd_in == seq_pkg::CMD_VIEW) begin
      capturing_out <= 1'b0;
    end else if (capturing_out && cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
      if (cnt_q == 16'h0001) begin
        capturing_out <= 1'b0;
      end
    end
  end
  // The memory byte stands only in the cycle after a read and toggles otherwise.
  always_ff @(posedge mclk_in) begin
    mem_data_out <= mem_rd_in ? (mem_addr_in[7:0] ^ {6'h00, mem_addr_in[9:8]} ^ pat_in) : ~mem_data_out;
  end
endmodule : analyzer_model

/* sim/testbench.sv */
// Purpose: Self-checking bench for the analyzer self-test sequencer.
// Assumes: Waits shortened to 40 and 10 cycles; wait register set to 1 us.
// Notes:   Pattern, counter bits and failing qualifier line come from a fixed seed.
`timescale 1ns/1ps
module testbench;
  logic        mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic        slow_clock_in = 1'b0, mem_full_in = 1'b1, qual_chk = 1'b0, irq_out, capturing_in;
  logic [3:0]  addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0, rdata_out, ec, d;
  logic [15:0] ctr_one_in = 16'h0, ctr_two_in = 16'h0, trig_dly = 16'h0, ctr_one_load_out, ctr_two_load_out, sum;
  logic [7:0]  mem_data_in, acq_delay_out, fe_latch_out, pat = 8'h00, bad_latch = 8'hFF;
  logic [1:0]  cmd_out, prog_out;
  logic [9:0]  mem_addr_out;
  logic        prog_wr_out, ctr_dec_mode_out, ctr_one_ms_out, ctr_two_us_out, fe_latch_wr_out, mem_rd_out;
  logic [7:0]  lv [6];
  logic [19:0] ccode [4] = '{seq_pkg::CODE_C1H, seq_pkg::CODE_C1L, seq_pkg::CODE_C2H, seq_pkg::CODE_C2L};
  int          error_cnt = 0, comparisons = 0, cyc = 0, seed = 32'hedc9, b, k, lw = 0, pw = 0;
  always #2.5 mclk_in = ~mclk_in;
  test_sequencer #(.WAIT1_CYCLES(40), .WAIT2_CYCLES(10)) test_sequencer_i (.mclk_in, .rst_in, .ce_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out, .capturing_in, .mem_full_in, .slow_clock_in, .ctr_one_in,
    .ctr_two_in, .mem_data_in, .cmd_out, .prog_out, .prog_wr_out, .ctr_one_load_out, .ctr_two_load_out,
    .ctr_dec_mode_out, .ctr_one_ms_out, .ctr_two_us_out, .acq_delay_out, .fe_latch_out, .fe_latch_wr_out,
    .mem_addr_out, .mem_rd_out);
  analyzer_model analyzer_model_i (.mclk_in, .rst_in, .cmd_in(cmd_out), .latch_in(fe_latch_out),
    .bad_latch_in(bad_latch), .qual_chk_in(qual_chk), .trig_dly_in(trig_dly), .mem_addr_in(mem_addr_out),
    .mem_rd_in(mem_rd_out), .pat_in(pat), .capturing_out(capturing_in), .mem_data_out(mem_data_in));
  function automatic logic [15:0] mem_sum(input logic [7:0] p);
    logic [15:0] s;
    s = 16'h0000;
    for (int a = 0; a < 1024; a++) s += {8'h00, 8'(a) ^ 8'(a >> 8) ^ p};
    return s;
  endfunction : mem_sum
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  // Starts a test, waits for it to finish, then checks verdict, code and interrupt.
  task automatic run(input logic [3:0] t, input logic [19:0] code, input logic [3:0] dig, input logic irq_exp);
    logic [31:0] v;
    int n;
    int p;
    p = pw;
    wr(seq_pkg::REG_CTRL, {24'h0, t, 4'h1});
    repeat (2) @(posedge mclk_in);
    n = 0;
    v = 32'h1;
    while (v[0] !== 1'b0 && n < 5000) begin
      rd(seq_pkg::REG_STATUS, v);
      n++;
    end
    chk("finished", 32'h0, {31'h0, v[0]});
    chk("prog writes", 32'(p + 1), 32'(pw));
    chk("passed", {31'h0, code == 20'h0}, {31'h0, v[1]});
    if (code != 20'h0) begin
      rd(seq_pkg::REG_FAIL, v);
      chk("fail word", {4'h0, t, code, dig}, v);
    end
    rd(seq_pkg::REG_ISTAT, v);
    chk("istat", {30'h0, code != 20'h0, code == 20'h0}, v);
    chk("irq", {31'h0, irq_exp}, {31'h0, irq_out});
    wr(seq_pkg::REG_ISTAT, 32'h3);
    repeat (2) @(posedge mclk_in);
    #1 chk("irq cleared", 32'h0, {31'h0, irq_out});
    $display("test %0d done", t);
    @(posedge mclk_in);
  endtask : run
  always @(posedge mclk_in) begin
    cyc++;
    if (fe_latch_wr_out) lw++;
    if (prog_wr_out) pw++;
    if (cyc == 90000) begin
      error_cnt++;
      $display("FAIL timeout expected finish seen hang");
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(4'hF, d);
    chk("unmapped", 32'h0, d);
    wr(seq_pkg::REG_IMASK, 32'h3);
    wr(seq_pkg::REG_WAIT, 32'h1);
    ce_in <= 1'b0;
    wr(seq_pkg::REG_WAIT, 32'h7);
    ce_in <= 1'b1;
    rd(seq_pkg::REG_WAIT, d);
    chk("ce freeze", 32'h1, d);
    ec = $random(seed);
    pat <= 8'($random(seed));
    wr(seq_pkg::REG_EXPCTR, ec);
    ctr_one_in    <= ec[31:16];
    ctr_two_in    <= ec[15:0];
    slow_clock_in <= 1'b1;
    run(4'h5, seq_pkg::CODE_SLOW, seq_pkg::DIG_SLOW, 1'b1);
    slow_clock_in <= 1'b0;
    trig_dly      <= 16'd45;
    run(4'h5, 20'h0, 4'h0, 1'b1);
    chk("ms preload", {seq_pkg::PRELOAD_MS, seq_pkg::PRELOAD_MS}, {ctr_one_load_out, ctr_two_load_out});
    chk("ms mode", {20'h0, prog_out, ctr_dec_mode_out, ctr_one_ms_out, acq_delay_out}, 32'h700);
    trig_dly <= 16'd20;
    run(4'h5, seq_pkg::CODE_EARLY, seq_pkg::DIG_EARLY1, 1'b1);
    trig_dly <= 16'd0;
    run(4'h5, seq_pkg::CODE_MON, seq_pkg::DIG_NOTRIG, 1'b1);
    trig_dly <= 16'd45;
    run(4'h6, 20'h0, 4'h0, 1'b1);
    chk("us preload", {seq_pkg::PRELOAD_US, seq_pkg::PRELOAD_US}, {ctr_one_load_out, ctr_two_load_out});
    chk("us mode", {30'h0, ctr_two_us_out, ctr_dec_mode_out}, 32'h3);
    wr(seq_pkg::REG_IMASK, 32'h0);
    trig_dly <= 16'd20;
    run(4'h6, seq_pkg::CODE_MON, seq_pkg::DIG_EARLY2, 1'b0);
    wr(seq_pkg::REG_IMASK, 32'h3);
    trig_dly    <= 16'd0;
    run(4'h4, seq_pkg::CODE_MON, seq_pkg::DIG_NOTRIG, 1'b1);
    trig_dly    <= 16'd50;
    mem_full_in <= 1'b0;
    run(4'h4, seq_pkg::CODE_MON, seq_pkg::DIG_FULL, 1'b1);
    mem_full_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      b = $unsigned($random(seed)) % 8;
      d = ec ^ (32'h1 << (8 * (3 - i) + b)) ^ ((i < 3) ? 32'h80 : 32'h0);
      ctr_one_in <= d[31:16];
      ctr_two_in <= d[15:0];
      run(4'h4, ccode[i], 4'(b), 1'b1);
    end
    ctr_one_in <= ec[31:16];
    ctr_two_in <= ec[15:0];
    sum = mem_sum(pat);
    b   = $unsigned($random(seed)) % 16;
    wr(seq_pkg::REG_EXPSUM, {16'h0, sum ^ (16'h1 << b)});
    run(4'h4, seq_pkg::CODE_SUM, 4'(b), 1'b1);
    wr(seq_pkg::REG_EXPSUM, {16'h0, sum});
    run(4'h4, 20'h0, 4'h0, 1'b1);
    chk("delay", {24'h0, seq_pkg::DELAY_T4}, {24'h0, acq_delay_out});
    for (int i = 0; i < 6; i++) lv[i] = (8'($random(seed)) & 8'hF8) | 8'(i);
    wr(seq_pkg::REG_QUALA, {lv[3], lv[2], lv[1], lv[0]});
    wr(seq_pkg::REG_QUALB, {16'h0, lv[5], lv[4]});
    qual_chk <= 1'b1;
    run(4'h7, 20'h0, 4'h0, 1'b1);
    k = $unsigned($random(seed)) % 6;
    bad_latch <= lv[k];
    run(4'h7, seq_pkg::CODE_QUAL + 20'(k), 4'h0, 1'b1);
    chk("stop line", {24'h0, lv[k]}, {24'h0, fe_latch_out});
    chk("latch writes", 32'(7 + k), 32'(lw));
    test_done();
  end
endmodule : testbench
